/* rtl/fpm_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE1] signed operands are two's complement; sign bit weighs negatively
// [RULE2] add and subtract give identical bits for signed or unsigned
// [RULE3] multiplier extends each operand per signed, unsigned or mixed select
// [RULE4] 16x16 multiply keeps the full 32-bit product
// [RULE5] fractional mode shifts the product left one bit
// [RULE6] integer mode writes the product unshifted
// [RULE7] one mode status bit chooses fractional or integer mode
// [RULE8] reset selects fractional mode
// [RULE9] exponent adjust counts redundant sign bits, updates only when fewer
// [RULE10] block exponent becomes max of itself and minus the count
module fpm_core
   import fpm_pkg::*;
(
   input  wire logic                 SYS_CLK,
   input  wire logic                 RESET_N,
   input  wire logic                 OP_VALID,
   input  wire fpm_pkg::fpm_op_type  OP_CODE,
   input  wire fpm_pkg::fpm_sign_type OP_SIGN,
   input  wire logic [15:0]          OP_X,
   input  wire logic [15:0]          OP_Y,
   input  wire logic                 MODE_FRAC_IN,
   input  wire logic [5:0]           BEXP_IN,
   output logic      [31:0]          RESULT,
   output logic                      RESULT_VALID,
   output logic                      MODE_FRAC,
   output logic      [5:0]           BLOCK_EXP
);
   import fpm_pkg::*;

   logic        [3:0]  sign_count;
   logic signed [16:0] x_ext;
   logic signed [16:0] y_ext;
   logic signed [33:0] full_prod;
   logic        [31:0] prod;
   logic        [31:0] next_result;
   logic signed [5:0]  neg_count;

   fpm_signbits u_signbits (
      .value (OP_X),
      .count (sign_count)
   );

   // a signed operand copies its msb, so it carries negative weight
   always_comb begin
      x_ext = {(OP_SIGN[1] & OP_X[15]), OP_X}; // [RULE1] [RULE3]
      y_ext = {(OP_SIGN[0] & OP_Y[15]), OP_Y}; // [RULE3]
      full_prod = x_ext * y_ext;
      prod = full_prod[31:0]; // [RULE4]
   end

   always_comb begin
      next_result = 32'h0;
      unique case (OP_CODE)
         FPM_OP_ADD: next_result = {16'h0, OP_X + OP_Y}; // [RULE2]
         FPM_OP_SUB: next_result = {16'h0, OP_X - OP_Y}; // [RULE2]
         FPM_OP_MUL: begin
            if (MODE_FRAC) begin
               next_result = prod << FRAC_SHIFT; // [RULE5]
            end else begin
               next_result = prod; // [RULE6]
            end
         end
         default: next_result = 32'h0;
      endcase
   end

   assign neg_count = -$signed({2'h0, sign_count});

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RESULT       <= 32'h0;
         RESULT_VALID <= 1'b0;
      end else begin
         RESULT_VALID <= OP_VALID & ((OP_CODE == FPM_OP_ADD) |
                         (OP_CODE == FPM_OP_SUB) | (OP_CODE == FPM_OP_MUL));
         // every valid op loads, so control ops also clear a stale product
         if (OP_VALID) begin
            RESULT <= next_result;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         MODE_FRAC <= MODE_FRAC_RESET; // [RULE8]
      end else if (OP_VALID && OP_CODE == FPM_OP_SETMOD) begin
         MODE_FRAC <= MODE_FRAC_IN; // [RULE7]
      end
   end

   // fewer redundant sign bits means a larger negated count
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         BLOCK_EXP <= BEXP_RESET;
      end else if (OP_VALID && OP_CODE == FPM_OP_SETEXP) begin
         BLOCK_EXP <= BEXP_IN;
      end else if (OP_VALID && OP_CODE == FPM_OP_EXP_ADJUST) begin
         if (neg_count > $signed(BLOCK_EXP)) begin // [RULE9]
            BLOCK_EXP <= neg_count; // [RULE10]
         end
      end
   end

   // shadow operands for the checks: extended apart from the datapath
   logic [31:0] chk_x;
   logic [31:0] chk_y;
   logic [31:0] chk_prod;

   // the low 32 bits of a product only need each operand extended right
   always_comb begin
      chk_x = OP_SIGN[1] ? 32'($signed(OP_X)) : 32'(OP_X);
      chk_y = OP_SIGN[0] ? 32'($signed(OP_Y)) : 32'(OP_Y);
      chk_prod = chk_x * chk_y;
   end

   a_mul_frac: assert property ( // [RULE5]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_MUL && MODE_FRAC |=>
      RESULT == {$past(chk_prod[30:0]), 1'b0})
      else $error("fractional product not shifted");

   a_mul_int: assert property ( // [RULE6]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_MUL && !MODE_FRAC |=>
      RESULT == $past(chk_prod))
      else $error("integer product altered");

   a_mul_ss: assert property ( // [RULE1] [RULE3] [RULE4]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_MUL && OP_SIGN == FPM_SS && !MODE_FRAC
      |=> $signed(RESULT) ==
      $past(32'($signed(OP_X)) * 32'($signed(OP_Y))))
      else $error("signed product wrong");

   a_mul_mixed: assert property ( // [RULE3]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_MUL && OP_SIGN == FPM_SU && !MODE_FRAC
      |=> RESULT == $past(32'($signed(OP_X)) * {16'h0, OP_Y}))
      else $error("mixed product wrong");

   a_mul_uu: assert property ( // [RULE3] [RULE4]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_MUL && OP_SIGN == FPM_UU && !MODE_FRAC
      |=> RESULT == $past({16'h0, OP_X} * {16'h0, OP_Y}))
      else $error("unsigned product wrong");

   a_add_bits: assert property ( // [RULE2]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_ADD |=> RESULT_VALID &&
      RESULT == {16'h0, $past(16'(OP_X + OP_Y))})
      else $error("sum wrong");

   a_sub_bits: assert property ( // [RULE2]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_SUB |=> RESULT_VALID &&
      RESULT == {16'h0, $past(16'(OP_X - OP_Y))})
      else $error("difference wrong");

   a_valid_drop: assert property ( // [RULE2]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      !(OP_VALID && OP_CODE inside {FPM_OP_ADD, FPM_OP_SUB, FPM_OP_MUL})
      |=> !RESULT_VALID)
      else $error("result flagged without arithmetic");

   a_mode_hold: assert property ( // [RULE7]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      !(OP_VALID && OP_CODE == FPM_OP_SETMOD) |=>
      $stable(MODE_FRAC))
      else $error("mode changed without set");

   a_mode_set: assert property ( // [RULE7]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_SETMOD |=>
      MODE_FRAC == $past(MODE_FRAC_IN))
      else $error("mode bit not taken");

   // no disable here: it must look at the edge where reset lets go
   a_mode_reset: assert property ( // [RULE8]
      @(posedge SYS_CLK) $rose(RESET_N) |-> MODE_FRAC)
      else $error("reset mode not fractional");

   a_exp_monotone: assert property ( // [RULE9]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_EXP_ADJUST |=>
      $signed(BLOCK_EXP) >= $signed($past(BLOCK_EXP)))
      else $error("block exponent decreased");

   a_exp_still: assert property ( // [RULE9]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_EXP_ADJUST && !BLOCK_EXP[5] |=>
      $stable(BLOCK_EXP))
      else $error("non-negative exponent moved");

   a_exp_zero: assert property ( // [RULE9] [RULE10]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_EXP_ADJUST && OP_X[15] != OP_X[14]
      && BLOCK_EXP[5] |=> BLOCK_EXP == 6'h00)
      else $error("no redundant sign bit but exponent kept");

   a_exp_max: assert property ( // [RULE10]
      @(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_EXP_ADJUST |=>
      $signed(BLOCK_EXP) >= $signed($past(neg_count)))
      else $error("block exponent below input");

   c_mul_frac: cover property (@(posedge SYS_CLK)
      OP_VALID && OP_CODE == FPM_OP_MUL && MODE_FRAC);

   c_mul_int: cover property (@(posedge SYS_CLK)
      OP_VALID && OP_CODE == FPM_OP_MUL && !MODE_FRAC);

   c_mul_mixed: cover property (@(posedge SYS_CLK)
      OP_VALID && OP_CODE == FPM_OP_MUL && OP_SIGN == FPM_SU);

   c_mode_int: cover property (@(posedge SYS_CLK)
      OP_VALID && OP_CODE == FPM_OP_SETMOD && !MODE_FRAC_IN);

   c_exp_up: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
      OP_VALID && OP_CODE == FPM_OP_EXP_ADJUST ##1 $changed(BLOCK_EXP));
endmodule // fpm_core
`default_nettype wire

/* rtl/fpm_pkg.sv */
`default_nettype none
package fpm_pkg;
   localparam int unsigned DATA_W   = 16;
   localparam int unsigned PROD_W   = 32;
   localparam int unsigned EXP_W    = 6;
   // one bit of shift in fractional mode
   localparam int unsigned FRAC_SHIFT = 1;
   // reset mode value: 1 selects fractional mode
   localparam logic        MODE_FRAC_RESET = 1'b1;
   // usual block exponent start, two guard bits
   localparam logic [5:0]  BEXP_RESET = 6'h3e;

   typedef enum logic [2:0] {
      FPM_OP_NOP        = 3'h0,
      FPM_OP_ADD        = 3'h1,
      FPM_OP_SUB        = 3'h2,
      FPM_OP_MUL        = 3'h3,
      FPM_OP_EXP_ADJUST = 3'h4,
      FPM_OP_SETEXP     = 3'h5,
      FPM_OP_SETMOD     = 3'h6
   } fpm_op_type;

   // operand signedness: bit 1 for x, bit 0 for y
   typedef enum logic [1:0] {
      FPM_UU = 2'h0,
      FPM_US = 2'h1,
      FPM_SU = 2'h2,
      FPM_SS = 2'h3
   } fpm_sign_type;
endpackage : fpm_pkg
`default_nettype wire

/* rtl/fpm_signbits.sv */
`timescale 1ns/1ps
`default_nettype none
// counts redundant sign bits: copies of the msb below it
module fpm_signbits (
   input  wire logic [15:0] value,
   output logic      [3:0]  count
);
   logic [15:0] run;
   assign run[15] = 1'b1;
   genvar i;
   generate
      for (i = 0; i < 15; i++) begin : g_run
         assign run[i] = run[i+1] & (value[i] == value[15]);
      end
   endgenerate
   always_comb begin
      count = 4'h0;
      for (int k = 0; k < 15; k++) begin
         if (run[k]) begin
            count = count + 4'h1;
         end
      end
   end
endmodule // fpm_signbits
`default_nettype wire

/* testbench/fpm_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// sequencer side: each op is presented just after a falling edge
module fpm_seq
   import fpm_pkg::*;
(
   input  wire logic             clk,
   output logic                  op_valid,
   output fpm_pkg::fpm_op_type   op_code,
   output fpm_pkg::fpm_sign_type op_sign,
   output logic [15:0]           op_x,
   output logic [15:0]           op_y,
   output logic                  mode_in,
   output logic [5:0]            bexp_in
);
   initial begin
      op_valid = 1'b0;
      op_code = FPM_OP_NOP;
      op_sign = FPM_SS;
      {op_x, op_y, mode_in, bexp_in} = '0;
   end
   // valid stays up across calls so ops run back to back
   task issue(fpm_op_type c, fpm_sign_type s, logic [15:0] x, y,
              logic m, logic [5:0] e);
      op_code = c;
      op_sign = s;
      {op_x, op_y, mode_in, bexp_in} = {x, y, m, e};
      op_valid = 1'b1;
      @(negedge clk);
   endtask
   task idle();
      op_valid = 1'b0;
      @(negedge clk);
   endtask
endmodule // fpm_seq
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   n_mismatch++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
   import fpm_pkg::*;
   logic         sys_clk = 1'b0, reset_n = 1'b0, op_valid, mode_in;
   logic         result_valid, mode_frac, m_frac, ev;
   fpm_op_type   op_code;
   fpm_sign_type op_sign;
   logic [15:0]  op_x, op_y;
   logic [5:0]   bexp_in, block_exp;
   logic [31:0]  result, er, px, py;
   int n_mismatch = 0, samples_checked = 0, cycles = 0, m_bexp, n;
   fpm_seq seq_u (.clk(sys_clk), .op_valid(op_valid), .op_code(op_code),
      .op_sign(op_sign), .op_x(op_x), .op_y(op_y), .mode_in(mode_in),
      .bexp_in(bexp_in));
   fpm_core dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .OP_VALID(op_valid), .OP_CODE(op_code), .OP_SIGN(op_sign),
      .OP_X(op_x), .OP_Y(op_y), .MODE_FRAC_IN(mode_in), .BEXP_IN(bexp_in),
      .RESULT(result), .RESULT_VALID(result_valid), .MODE_FRAC(mode_frac),
      .BLOCK_EXP(block_exp));
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         summarize();
      end
   end
   task summarize();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task do_reset();
      reset_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      `CHK("mode", 1'b1, mode_frac)
      `CHK("bexp", 6'h3e, block_exp)
      reset_n = 1'b1;
      m_frac = 1'b1;
      m_bexp = -2;
   endtask
   task run(fpm_op_type c, fpm_sign_type s, logic [15:0] x, y,
            logic m, logic [5:0] e);
      px = s[1] ? {{16{x[15]}}, x} : {16'h0, x};
      py = s[0] ? {{16{y[15]}}, y} : {16'h0, y};
      er = 32'h0;
      ev = c inside {FPM_OP_ADD, FPM_OP_SUB, FPM_OP_MUL};
      if (c == FPM_OP_ADD) er = {16'h0, x + y};
      if (c == FPM_OP_SUB) er = {16'h0, x - y};
      if (c == FPM_OP_MUL) er = (px * py) << m_frac;
      n = 0;
      while (n < 15 && x[14-n] == x[15]) n++;
      if (c == FPM_OP_EXP_ADJUST && -n > m_bexp) m_bexp = -n;
      if (c == FPM_OP_SETEXP) m_bexp = $signed(e);
      if (c == FPM_OP_SETMOD) m_frac = m;
      seq_u.issue(c, s, x, y, m, e);
      `CHK("result", er, result)
      `CHK("valid", ev, result_valid)
      `CHK("mode", m_frac, mode_frac)
      `CHK("bexp", m_bexp[5:0], block_exp)
   endtask
   initial begin
      void'($urandom(32'h67a7ef32));
      do_reset();
      run(FPM_OP_MUL, FPM_SS, 16'h4000, 16'h4000, 1'b0, 6'h0);
      run(FPM_OP_EXP_ADJUST, FPM_SS, 16'h1fff, 16'h0, 1'b0, 6'h0);
      run(FPM_OP_EXP_ADJUST, FPM_SS, 16'h3fff, 16'h0, 1'b0, 6'h0);
      run(FPM_OP_SETMOD, FPM_SS, 16'h0, 16'h0, 1'b0, 6'h0);
      run(FPM_OP_MUL, FPM_SU, 16'hffff, 16'hffff, 1'b0, 6'h0);
      repeat (400) run(fpm_op_type'($urandom_range(6)),
         fpm_sign_type'($urandom_range(3)), 16'($urandom),
         16'($urandom), 1'($urandom), 6'($urandom));
      run(FPM_OP_SETMOD, FPM_SS, 16'h0, 16'h0, 1'b0, 6'h0);
      seq_u.idle();
      // a second reset mid-run must bring fractional mode back
      do_reset();
      run(FPM_OP_MUL, FPM_UU, 16'hffff, 16'h8000, 1'b0, 6'h0);
      seq_u.idle();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
